/* File: shared/sscfg_pkg.sv */
// constants and types for the switch strap and serial rom pin logic
// Overview of operation
// - the upstream select strap picks port 0 for 00, port 1 for 01 and port 2 for 11, and 10 is reserved.
// - a high payload strap advertises a 512 byte maximum payload, a low one 256 bytes.
// - during initialization the rom select pin is read as a bypass strap, low disables the rom, high enables it.
// - after initialization the rom select output is driven low whenever the rom is being accessed.
// - a four wire rom port supplies the rom clock, shifts data to the rom and samples data from it.
// - a reference clock output runs while its matching active low request input is held low by the board.
// - software may switch reference clock outputs off through the configuration register at offset 98h.
// - the management clock and data pins are open drain, only pulled low or released, with data two-way.
// - the active low system reset initializes all internal state except the pin synchronisers, which only nrst clears.
// - payload strap and upstream select bit 0 are sampled as inputs at initialization and may be debug outputs later.
package sscfg_pkg;
   localparam logic [7:0]  SSCFG_CLK_DISABLE_OFFSET = 8'h98;
   localparam int          SSCFG_NUM_REFCLK_REQ     = 3;
   localparam int          SSCFG_NUM_DEBUG          = 5;
   localparam int          SSCFG_DEBUG_PAYLOAD_BIT  = 0;
   localparam int          SSCFG_DEBUG_UPS0_BIT     = 3;
   localparam logic [1:0]  SSCFG_UPS_PORT0          = 2'h0;
   localparam logic [1:0]  SSCFG_UPS_PORT1          = 2'h1;
   localparam logic [1:0]  SSCFG_UPS_RESERVED       = 2'h2;
   localparam logic [1:0]  SSCFG_UPS_PORT2          = 2'h3;
   localparam logic [2:0]  SSCFG_MPS_256            = 3'h1;
   localparam logic [2:0]  SSCFG_MPS_512            = 3'h2;
   localparam int          SSCFG_CLK_HZ             = 200000000;
   localparam int          SSCFG_ROM_HALF_NS        = 500;
   localparam int          SSCFG_ROM_HALF_CYC       = (SSCFG_ROM_HALF_NS * (SSCFG_CLK_HZ / 1000000)) / 1000;
   localparam int          SSCFG_ROM_CMD_BITS       = 11;
   localparam int          SSCFG_ROM_DATA_BITS      = 16;
   localparam int          SSCFG_SETTLE_CYC         = 4;
   localparam logic [1:0]  SSCFG_ROM_READ_OP        = 2'h2;
   typedef enum logic [1:0] {SSCFG_ST_IDLE, SSCFG_ST_CMD, SSCFG_ST_DATA, SSCFG_ST_DONE} sscfg_rom_state_t;
endpackage

/* File: logic/sscfg_rom_port.sv */
// serial rom shifter: 3-wire data plus active low select, one word read per request
`timescale 1ns/10ps
`default_nettype none
module sscfg_rom_port
   import sscfg_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              rom_enable,
   input  wire logic              start,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              miso_sync,
   output logic                   busy,
   output logic                   done,
   output logic [15:0]            rdata,
   output logic                   rom_clk,
   output logic                   rom_sel_n,
   output logic                   rom_mosi
);
   localparam int CMD_W = 2 + ADDR_W + 1;
   sscfg_rom_state_t   state_reg, state_next;
   logic [15:0]        div_reg;
   logic [5:0]         bit_reg;
   logic [CMD_W-1:0]   cmd_reg;
   logic [15:0]        data_reg;
   logic               sclk_reg;
   wire                tick      = (div_reg == 16'(SSCFG_ROM_HALF_CYC - 1));
   wire                fall_tick = tick & sclk_reg;
   wire                rise_tick = tick & ~sclk_reg;
   wire                cmd_last  = (bit_reg == 6'(CMD_W - 1));
   wire                data_last = (bit_reg == 6'(SSCFG_ROM_DATA_BITS - 1));
   wire                active    = (state_reg == SSCFG_ST_CMD) | (state_reg == SSCFG_ST_DATA);

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         SSCFG_ST_IDLE: if (start & rom_enable) state_next = SSCFG_ST_CMD;
         SSCFG_ST_CMD:  if (fall_tick & cmd_last) state_next = SSCFG_ST_DATA;
         SSCFG_ST_DATA: if (fall_tick & data_last) state_next = SSCFG_ST_DONE;
         default:       state_next = SSCFG_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state_reg <= SSCFG_ST_IDLE;
         div_reg   <= 16'h0000;
         bit_reg   <= 6'h00;
         cmd_reg   <= '0;
         data_reg  <= 16'h0000;
         sclk_reg  <= 1'b0;
         rom_clk   <= 1'b0;
         rom_sel_n <= 1'b1;
         rom_mosi  <= 1'b0;
         done      <= 1'b0;
         rdata     <= 16'h0000;
         busy      <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         // registered from the next state so busy rises on the same edge that the state leaves idle
         busy      <= (state_next != SSCFG_ST_IDLE);
         done      <= (state_reg == SSCFG_ST_DONE);
         div_reg   <= (active & ~tick) ? div_reg + 16'h0001 : 16'h0000;
         if (state_reg == SSCFG_ST_IDLE && state_next == SSCFG_ST_CMD)
         begin
            cmd_reg <= {1'b1, SSCFG_ROM_READ_OP, addr};
            bit_reg <= 6'h00;
         end
         else if (fall_tick)
         begin
            cmd_reg <= {cmd_reg[CMD_W-2:0], 1'b0};
            bit_reg <= (cmd_last && state_reg == SSCFG_ST_CMD) ? 6'h00 : bit_reg + 6'h01;
         end
         if (rise_tick && state_reg == SSCFG_ST_DATA)
            data_reg <= {data_reg[14:0], miso_sync};
         if (active & tick)
            sclk_reg <= ~sclk_reg;
         else if (!active)
            sclk_reg <= 1'b0;
         rom_clk   <= active & rom_enable & sclk_reg;
         rom_sel_n <= ~(active & rom_enable);
         rom_mosi  <= (state_reg == SSCFG_ST_CMD) & cmd_reg[CMD_W-1];
         if (state_reg == SSCFG_ST_DONE)
            rdata <= data_reg;
      end
   end

endmodule
`default_nettype wire

/* File: logic/sscfg_strap_rom.sv */
// strap capture, reference clock gating, open drain management pins and rom port wrapper
`timescale 1ns/10ps
`default_nettype none
module sscfg_strap_rom
   import sscfg_pkg::*;
#(
   parameter int NUM_REQ = SSCFG_NUM_REFCLK_REQ,
   parameter int ADDR_W  = 8
)
(
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      system_reset_n,
   input  wire logic [1:0]                upstream_port_select,
   input  wire logic                      payload_size_strap,
   input  wire logic [NUM_REQ-1:0]        ref_clock_request_n,
   input  wire logic [NUM_REQ-1:0]        ref_clock_sw_disable,
   input  wire logic                      rom_read_start,
   input  wire logic [ADDR_W-1:0]         rom_read_addr,
   output logic                           rom_read_busy,
   output logic                           rom_read_done,
   output logic [15:0]                    rom_read_data,
   input  wire logic                      serial_rom_select_n_in,
   output logic                           serial_rom_select_n,
   output logic                           serial_rom_select_oe,
   output logic                           serial_rom_clock,
   output logic                           serial_rom_clock_oe,
   output logic                           serial_rom_data_to_rom,
   input  wire logic                      serial_rom_data_from_rom,
   input  wire logic                      mgmt_scl_in,
   output logic                           mgmt_scl_out,
   output logic                           mgmt_scl_oe,
   input  wire logic                      mgmt_sda_in,
   output logic                           mgmt_sda_out,
   output logic                           mgmt_sda_oe,
   input  wire logic                      mgmt_scl_pull_low,
   input  wire logic                      mgmt_sda_pull_low,
   output logic                           mgmt_scl_seen,
   output logic                           mgmt_sda_seen,
   input  wire logic [SSCFG_NUM_DEBUG-1:0] debug_status,
   output logic [SSCFG_NUM_DEBUG-1:0]     debug_out,
   output logic [SSCFG_NUM_DEBUG-1:0]     debug_out_oe,
   output logic                           init_done,
   output logic [1:0]                     upstream_port,
   output logic                           upstream_reserved,
   output logic [2:0]                     max_payload_code,
   output logic                           rom_enabled,
   output logic [NUM_REQ-1:0]             ref_clock_enable
);
   logic [1:0]          rst_meta_reg, ups0_meta_reg, ups1_meta_reg, pl_meta_reg, cs_meta_reg, do_meta_reg;
   logic [1:0]          scl_meta_reg, sda_meta_reg;
   logic [NUM_REQ-1:0]  req_meta_reg, req_sync_reg;
   logic [3:0]          settle_reg;
   logic                captured_reg;
   logic                rom_clk_w, rom_sel_w, rom_mosi_w;

   // only the second stage of each synchroniser is read
   wire sys_rst_n  = rst_meta_reg[1];
   wire chip_rst_n = nrst & sys_rst_n;
   wire settled    = (settle_reg == 4'(SSCFG_SETTLE_CYC));
   wire ups_res    = ({ups1_meta_reg[1], ups0_meta_reg[1]} == SSCFG_UPS_RESERVED);
   wire [1:0] ups_port = ({ups1_meta_reg[1], ups0_meta_reg[1]} == SSCFG_UPS_PORT2) ? 2'h2 :
                         ({ups1_meta_reg[1], ups0_meta_reg[1]} == SSCFG_UPS_PORT1) ? 2'h1 : 2'h0;
   wire [2:0] mps_code = pl_meta_reg[1] ? SSCFG_MPS_512 : SSCFG_MPS_256;

   // board pins change with no regard to clk, so two stages before any logic reads them
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         rst_meta_reg  <= 2'h0;
         ups0_meta_reg <= 2'h0;
         ups1_meta_reg <= 2'h0;
         pl_meta_reg   <= 2'h0;
         cs_meta_reg   <= 2'h3;
         do_meta_reg   <= 2'h0;
         scl_meta_reg  <= 2'h3;
         sda_meta_reg  <= 2'h3;
      end
      else
      begin
         rst_meta_reg  <= {rst_meta_reg[0], system_reset_n};
         ups0_meta_reg <= {ups0_meta_reg[0], upstream_port_select[0]};
         ups1_meta_reg <= {ups1_meta_reg[0], upstream_port_select[1]};
         pl_meta_reg   <= {pl_meta_reg[0], payload_size_strap};
         cs_meta_reg   <= {cs_meta_reg[0], serial_rom_select_n_in};
         do_meta_reg   <= {do_meta_reg[0], serial_rom_data_from_rom};
         scl_meta_reg  <= {scl_meta_reg[0], mgmt_scl_in};
         sda_meta_reg  <= {sda_meta_reg[0], mgmt_sda_in};
      end
   end

   // requests idle high, so the chain resets to idle and no clock starts straight out of reset
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         req_meta_reg  <= '1;
         req_sync_reg  <= '1;
      end
      else
      begin
         req_meta_reg  <= ref_clock_request_n;
         req_sync_reg  <= req_meta_reg;
      end
   end

   // straps settle a few cycles after reset release, then are frozen until the next reset
   always_ff @(posedge clk)
   begin
      if (!chip_rst_n)
      begin
         settle_reg        <= 4'h0;
         captured_reg      <= 1'b0;
         init_done         <= 1'b0;
         upstream_port     <= 2'h0;
         upstream_reserved <= 1'b0;
         max_payload_code  <= SSCFG_MPS_256;
         rom_enabled       <= 1'b0;
      end
      else
      begin
         if (!settled)
            settle_reg <= settle_reg + 4'h1;
         if (settled && !captured_reg)
         begin
            captured_reg      <= 1'b1;
            upstream_port     <= ups_port;
            upstream_reserved <= ups_res;
            max_payload_code  <= mps_code;
            rom_enabled       <= cs_meta_reg[1];
         end
         init_done <= captured_reg;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!chip_rst_n)
      begin
         ref_clock_enable <= '0;
      end
      else
      begin
         ref_clock_enable <= ~req_sync_reg & ~ref_clock_sw_disable;
      end
   end

   // select pin is only driven once the bypass strap has been read
   always_ff @(posedge clk)
   begin
      if (!chip_rst_n)
      begin
         serial_rom_select_n    <= 1'b1;
         serial_rom_select_oe   <= 1'b0;
         serial_rom_clock       <= 1'b0;
         serial_rom_clock_oe    <= 1'b0;
         serial_rom_data_to_rom <= 1'b0;
      end
      else
      begin
         serial_rom_select_n    <= rom_sel_w;
         serial_rom_select_oe   <= init_done & rom_enabled;
         serial_rom_clock       <= rom_clk_w;
         serial_rom_clock_oe    <= init_done & rom_enabled;
         serial_rom_data_to_rom <= rom_mosi_w;
      end
   end

   // these pins are only ever pulled low, the board pull-ups give the high level
   always_ff @(posedge clk)
   begin
      if (!chip_rst_n)
      begin
         mgmt_scl_out  <= 1'b0;
         mgmt_scl_oe   <= 1'b0;
         mgmt_sda_out  <= 1'b0;
         mgmt_sda_oe   <= 1'b0;
         mgmt_scl_seen <= 1'b1;
         mgmt_sda_seen <= 1'b1;
      end
      else
      begin
         mgmt_scl_out  <= 1'b0;
         mgmt_scl_oe   <= mgmt_scl_pull_low;
         mgmt_sda_out  <= 1'b0;
         mgmt_sda_oe   <= mgmt_sda_pull_low;
         mgmt_scl_seen <= scl_meta_reg[1];
         mgmt_sda_seen <= sda_meta_reg[1];
      end
   end

   // debug pins stay undriven until the straps sharing them have been captured
   always_ff @(posedge clk)
   begin
      if (!chip_rst_n)
      begin
         debug_out    <= '0;
         debug_out_oe <= '0;
      end
      else
      begin
         debug_out    <= debug_status;
         debug_out_oe <= {SSCFG_NUM_DEBUG{init_done}};
      end
   end

   sscfg_rom_port #(.ADDR_W(ADDR_W)) u_rom
   (
      .clk        (clk),
      .nrst       (chip_rst_n),
      .rom_enable (init_done & rom_enabled),
      .start      (rom_read_start),
      .addr       (rom_read_addr),
      .miso_sync  (do_meta_reg[1]),
      .busy       (rom_read_busy),
      .done       (rom_read_done),
      .rdata      (rom_read_data),
      .rom_clk    (rom_clk_w),
      .rom_sel_n  (rom_sel_w),
      .rom_mosi   (rom_mosi_w)
   );
endmodule
`default_nettype wire

/* File: tb/sscfg_strap_rom_sva.sv */
// assertions on strap capture, clock request gating and rom select pins
`timescale 1ns/10ps
`default_nettype none
module sscfg_strap_rom_sva
   import sscfg_pkg::*;
#(
   parameter int NUM_REQ = SSCFG_NUM_REFCLK_REQ
)
(
   input wire logic               clk,
   input wire logic               nrst,
   input wire logic               system_reset_n,
   input wire logic [1:0]         upstream_port_select,
   input wire logic               payload_size_strap,
   input wire logic [NUM_REQ-1:0] ref_clock_request_n,
   input wire logic [NUM_REQ-1:0] ref_clock_sw_disable,
   input wire logic               rom_read_busy,
   input wire logic               serial_rom_select_n_in,
   input wire logic               serial_rom_select_n,
   input wire logic               serial_rom_select_oe,
   input wire logic               serial_rom_clock_oe,
   input wire logic               init_done,
   input wire logic [1:0]         upstream_port,
   input wire logic               upstream_reserved,
   input wire logic [2:0]         max_payload_code,
   input wire logic               rom_enabled,
   input wire logic [NUM_REQ-1:0] ref_clock_enable
);
   logic [3:0] hist;
   // the board reset passes a synchroniser, so checks wait until its delayed release is over
   always_ff @(posedge clk) hist <= nrst ? {hist[2:0], system_reset_n} : 4'h0;
   wire logic run_ok = nrst && system_reset_n && (&hist);
   wire logic [1:0] ups_exp = (upstream_port_select == 2'h3) ? 2'h2 : {1'b0, upstream_port_select == 2'h1};
   default clocking @(posedge clk); endclocking
   default disable iff (!run_ok);
   property p_ups;
      $rose(init_done) |-> upstream_port == $past(ups_exp)
         && upstream_reserved == ($past(upstream_port_select) == SSCFG_UPS_RESERVED);
   endproperty
   a_ups: assert property (p_ups) else $error("upstream port decode wrong");
   property p_caps;
      $rose(init_done) |-> rom_enabled == $past(serial_rom_select_n_in)
         && max_payload_code == ($past(payload_size_strap) ? SSCFG_MPS_512 : SSCFG_MPS_256);
   endproperty
   a_caps: assert property (p_caps) else $error("payload or rom strap wrong");
   property p_hold;
      init_done && $past(init_done) |-> $stable({upstream_port, upstream_reserved, max_payload_code, rom_enabled});
   endproperty
   a_hold: assert property (p_hold) else $error("captured strap changed");
   property p_bypass; !rom_enabled |-> serial_rom_select_n && !serial_rom_select_oe && !serial_rom_clock_oe; endproperty
   a_bypass: assert property (p_bypass) else $error("rom pins active while bypassed");
   // select passes the shifter register and the pin register, so it falls two edges after busy rises
   property p_sel;
      $rose(rom_read_busy) |-> ##2 (!serial_rom_select_n && serial_rom_select_oe);
   endproperty
   a_sel: assert property (p_sel) else $error("rom select not driven low");
   property p_ref_on;
      (ref_clock_request_n == '0 && ref_clock_sw_disable == '0) [*8] |-> ref_clock_enable == '1;
   endproperty
   a_ref_on: assert property (p_ref_on) else $error("requested clock not enabled");
   property p_ref_off; |ref_clock_sw_disable |=> (ref_clock_enable & $past(ref_clock_sw_disable)) == '0; endproperty
   a_ref_off: assert property (p_ref_off) else $error("disabled clock still on");
   property p_rst; disable iff (!nrst) !system_reset_n [*4] |=> !init_done && ref_clock_enable == '0; endproperty
   a_rst: assert property (p_rst) else $error("board reset did not clear state");
endmodule
`default_nettype wire

/* File: tb/sscfg_rom_model.sv */
// serial rom model: takes a read command and answers with a word built from its address
`timescale 1ns/10ps
`default_nettype none
module sscfg_rom_model
(
   input  wire logic sel_n,
   input  wire logic sck,
   input  wire logic di,
   output var logic  dout
);
   logic [10:0] cmd;
   logic [15:0] word;
   int          n = 0;
   initial dout = 1'b0;
   // a released data line flips rather than keeping a stale bit
   always @(posedge sel_n) dout = ~dout;
   always @(posedge sel_n) n = 0;
   always @(posedge sck) if (!sel_n) cmd = {cmd[9:0], di};
   always @(posedge sck) if (!sel_n) n = n + 1;
   // only a proper read command gets the word, anything else reads back zero
   always @(negedge sck)
   begin
      if (!sel_n && n == 11) word = (cmd[10:8] == 3'h6) ? {~cmd[7:0], cmd[7:0]} : 16'h0;
      if (!sel_n && n >= 11) {dout, word} = {word, 1'b0};
   end
endmodule
`default_nettype wire

/* File: tb/tb_sscfg_strap_rom.sv */
// self-checking bench for the strap, clock request and serial rom pin logic
`timescale 1ns/10ps
`default_nettype none
module tb_sscfg_strap_rom;
   import sscfg_pkg::*;
   logic clk, nrst, system_reset_n, payload_size_strap, rom_read_start, bypass_strap, rom_read_busy;
   logic rom_read_done, serial_rom_select_n, serial_rom_select_oe, serial_rom_clock, serial_rom_clock_oe;
   logic serial_rom_data_to_rom, serial_rom_data_from_rom, init_done, upstream_reserved, rom_enabled;
   logic mgmt_scl_out, mgmt_scl_oe, mgmt_sda_out, mgmt_sda_oe, mgmt_scl_pull_low, mgmt_sda_pull_low;
   logic mgmt_scl_seen, mgmt_sda_seen;
   logic [1:0] upstream_port_select, upstream_port;
   logic [2:0] ref_clock_request_n, ref_clock_sw_disable, ref_clock_enable, max_payload_code;
   logic [4:0] debug_status, debug_out, debug_out_oe;
   logic [7:0] rom_read_addr;
   logic [15:0] rom_read_data;
   wire logic serial_rom_select_n_in, mgmt_scl_in, mgmt_sda_in;
   int num_errors, tests_run, cyc;
   logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   logic [1:0] ports [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
   // the strap resistor sets the select pin only while the device leaves it undriven
   assign serial_rom_select_n_in = serial_rom_select_oe ? serial_rom_select_n : bypass_strap;
   assign mgmt_scl_in = !(mgmt_scl_oe && !mgmt_scl_out);
   assign mgmt_sda_in = !(mgmt_sda_oe && !mgmt_sda_out);
   sscfg_strap_rom dut (.*);
   sscfg_rom_model rom (.sel_n(serial_rom_select_n_in), .sck(serial_rom_clock & serial_rom_clock_oe),
                        .di(serial_rom_data_to_rom), .dout(serial_rom_data_from_rom));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
      if (++cyc == 20000) print_verdict(1);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic start_up(input logic [1:0] ups, input logic pl, input logic byp);
      @(posedge clk);
      {upstream_port_select, payload_size_strap, bypass_strap, nrst} <= {ups, pl, byp, 1'b0};
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge clk);
   endtask
   task automatic rom_read(input logic [7:0] a);
      @(posedge clk);
      {rom_read_addr, rom_read_start} <= {a, 1'b1};
      repeat (5) @(posedge clk);
      rom_read_start <= 1'b0;
      @(negedge clk);
      chk({serial_rom_select_oe, serial_rom_select_n}, 2'h2, "select");
      for (int i = 0; i < 8000 && rom_read_done !== 1'b1; i++) @(negedge clk);
      chk(rom_read_data, {~a, a}, "word");
      look(3);
      chk(serial_rom_select_n, 1'b1, "deselect");
   endtask
   task automatic print_verdict(input int late);
      num_errors += late;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      {nrst, system_reset_n, rom_read_start, rom_read_addr, bypass_strap} = {2'h1, 9'h0, 1'b1};
      {upstream_port_select, payload_size_strap, ref_clock_request_n, ref_clock_sw_disable} = 9'h38;
      {mgmt_scl_pull_low, mgmt_sda_pull_low, debug_status} = 7'h0;
      for (int k = 0; k < 4; k++)
      begin
         start_up(codes[k], k[0], 1'b1);
         chk({upstream_reserved, upstream_port}, {k == 3, ports[k]}, "port");
         chk({rom_enabled, max_payload_code}, {1'b1, k[0] ? SSCFG_MPS_512 : SSCFG_MPS_256}, "caps");
         @(posedge clk);
         {upstream_port_select, payload_size_strap, debug_status} <= {~codes[k], ~k[0], 5'(k + 9)};
         look(8);
         chk(upstream_port, ports[k], "held");
         chk({debug_out_oe, debug_out}, {5'h1f, 5'(k + 9)}, "debug");
      end
      $display("strap test done");
      for (int b = 0; b < 3; b++)
      begin
         @(posedge clk);
         {ref_clock_request_n, ref_clock_sw_disable} <= {~(3'h1 << b), 3'h0};
         look(5);
         chk(ref_clock_enable, 3'h1 << b, "ref on");
         @(posedge clk);
         ref_clock_sw_disable <= 3'h7;
         look(2);
         chk(ref_clock_enable, 3'h0, "ref off");
      end
      @(posedge clk);
      {ref_clock_request_n, ref_clock_sw_disable, mgmt_scl_pull_low, mgmt_sda_pull_low} <= 8'h3;
      look(9);
      chk(ref_clock_enable, 3'h7, "ref all");
      chk({mgmt_scl_oe, mgmt_sda_oe, mgmt_scl_out, mgmt_sda_out, mgmt_scl_seen, mgmt_sda_seen}, 6'h30, "od");
      @(posedge clk);
      {mgmt_scl_pull_low, mgmt_sda_pull_low, system_reset_n} <= 3'h0;
      look(5);
      chk({init_done, ref_clock_enable, mgmt_scl_oe, mgmt_scl_seen}, 6'h01, "board reset");
      @(posedge clk);
      system_reset_n <= 1'b1;
      $display("pin test done");
      start_up(2'h1, 1'b0, 1'b0);
      @(posedge clk);
      rom_read_start <= 1'b1;
      look(300);
      chk({rom_enabled, rom_read_busy, serial_rom_select_oe, serial_rom_clock_oe}, 4'h0, "bypass");
      @(posedge clk);
      rom_read_start <= 1'b0;
      start_up(2'h0, 1'b1, 1'b1);
      rom_read(8'h3c);
      rom_read(8'hc5);
      $display("rom test done");
      print_verdict(0);
   end
endmodule
bind sscfg_strap_rom sscfg_strap_rom_sva #(.NUM_REQ(NUM_REQ)) u_sva
(
   .clk                    (clk),
   .nrst                   (nrst),
   .system_reset_n         (system_reset_n),
   .upstream_port_select   (upstream_port_select),
   .payload_size_strap     (payload_size_strap),
   .ref_clock_request_n    (ref_clock_request_n),
   .ref_clock_sw_disable   (ref_clock_sw_disable),
   .rom_read_busy          (rom_read_busy),
   .serial_rom_select_n_in (serial_rom_select_n_in),
   .serial_rom_select_n    (serial_rom_select_n),
   .serial_rom_select_oe   (serial_rom_select_oe),
   .serial_rom_clock_oe    (serial_rom_clock_oe),
   .init_done              (init_done),
   .upstream_port          (upstream_port),
   .upstream_reserved      (upstream_reserved),
   .max_payload_code       (max_payload_code),
   .rom_enabled            (rom_enabled),
   .ref_clock_enable       (ref_clock_enable)
);
`default_nettype wire
